// [hdl/dcp_device.sv]
/*
 Controller end: decodes port microinstructions, starts functions,
 raises the fast request and the slow interrupt.
 Assumes the processor end supplies the timing pulses.
*/
// How it works
// - Act only on phase and port pulses
// - Transfer function done raises fast request
// - Processor acknowledges fast request with grant
// - Slow interrupt on completion, status change, error
// - Byte or longword data, agreed size
// - Words arrive on the port data bus
// - Select line and code field pick operation
// - Fresh control word before every function
// - Control word gives function, drive, skip, start
// - Completion interrupt only if requested
// - Accept the five drive command kinds
// - Cleared ready bit starts the function
// - Interrupt enable gates slow interrupt
`default_nettype none
module dcp_device (
    input  wire logic   hclk,
    input  wire logic   hresetn,
    dcp_port_if.dev     pio,
    input  wire logic   func_done,
    input  wire logic   func_error,
    input  wire logic   drive_change,
    input  wire logic [31:0] rd_data,
    output logic        func_start,
    output logic [2:0]  func_code,
    output logic [1:0]  drive_sel,
    output logic        skip_sector_en,
    output logic        maint_mode,
    output logic        format_mode,
    output logic        write_inhibit,
    output logic        busy,
    output logic        dcmd_valid,
    output logic [2:0]  dcmd_kind,
    output logic [31:0] dcmd_word,
    output logic        wr_valid,
    output logic [31:0] wr_data,
    output logic        wr_byte
);
    typedef enum logic [1:0] {
        DV_IDLE,
        DV_BUSY,
        DV_XFER
    } dcp_dev_state_t;

    typedef struct packed {
        dcp_dev_state_t st;
        logic [2:0]     func;
        logic [1:0]     drive;
        logic           skip_en;
        logic           mtn;
        logic           fmt;
        logic           winh;
        logic           ie;
        logic           err;
        logic           start;
        logic           xfer_req;
        logic           slow_irq;
        logic           done_p;
        logic           err_p;
        logic           chg_p;
        logic [31:0]    ret;
        logic           dcmd_v;
        logic [2:0]     dcmd_kind;
        logic [31:0]    dcmd_word;
        logic           wr_v;
        logic [31:0]    wr_data;
        logic           wr_byte;
    } dcp_dev_t;

    dcp_dev_t r_reg;
    dcp_dev_t r_next;

    logic        accept;
    logic [31:0] y;
    logic [31:0] status_word;
    logic        xfer_func;
    logic [2:0]  kind;

    always_comb begin
        y = pio.port_data_bus;
        kind = y[2:0];
        accept = pio.port_instruction_strobe && pio.processor_phase_pulse
            && pio.microinstruction_select_line;
        xfer_func = (r_reg.func == dcp_pkg::FN_WR_CHECK) || (r_reg.func == dcp_pkg::FN_WR_DATA)
            || (r_reg.func == dcp_pkg::FN_RD_DATA) || (r_reg.func == dcp_pkg::FN_RD_NOHDR);
        status_word = '0;
        status_word[dcp_pkg::SW_READY] = (r_reg.st == DV_IDLE);
        status_word[dcp_pkg::SW_XFER] = r_reg.xfer_req;
        status_word[dcp_pkg::SW_SLOW] = r_reg.slow_irq;
        status_word[dcp_pkg::SW_ERR] = r_reg.err;
        status_word[dcp_pkg::SW_DS_LSB +: 2] = r_reg.drive;
    end

    always_comb begin
        r_next = r_reg;
        r_next.start = 1'b0;
        r_next.dcmd_v = 1'b0;
        r_next.wr_v = 1'b0;
        // Events wait for the next port pulse
        r_next.done_p = r_reg.done_p | func_done;
        r_next.err_p = r_reg.err_p | func_error;
        r_next.chg_p = r_reg.chg_p | drive_change;

        if (accept) begin
            case (pio.microinstruction_code_field)
                dcp_pkg::UC_CTRL_WORD: begin
                    // A new control word retires the previous interrupt
                    r_next.slow_irq = 1'b0;
                    r_next.ie = y[dcp_pkg::CW_IE];
                    // Ignored while busy: a function runs only from its own word
                    if (!y[dcp_pkg::CW_CONTROLLER_READY_FLAG] && r_reg.st == DV_IDLE) begin
                        r_next.func = y[dcp_pkg::CW_FN_LSB +: 3];
                        r_next.drive = y[dcp_pkg::CW_DS_LSB +: 2];
                        r_next.skip_en = !y[dcp_pkg::CW_ASSI];
                        r_next.mtn = y[dcp_pkg::CW_MTN];
                        r_next.fmt = y[dcp_pkg::CW_FMT];
                        r_next.winh = y[dcp_pkg::CW_WINH];
                        r_next.err = 1'b0;
                        r_next.done_p = func_done;
                        r_next.err_p = func_error;
                        r_next.start = 1'b1;
                        r_next.st = DV_BUSY;
                    end
                end
                dcp_pkg::UC_DRV_CMD: begin
                    r_next.dcmd_word = y;
                    r_next.dcmd_kind = kind;
                    r_next.dcmd_v = (kind == dcp_pkg::DK_GET_STATUS)
                        || (kind == dcp_pkg::DK_SEEK_A) || (kind == dcp_pkg::DK_SEEK_B)
                        || (kind == dcp_pkg::DK_HEAD_SEL)
                        || (kind == dcp_pkg::DK_RECAL);
                end
                dcp_pkg::UC_RD_STATUS: begin
                    r_next.ret = status_word;
                end
                dcp_pkg::UC_WR_DATA: begin
                    r_next.wr_v = 1'b1;
                    r_next.wr_byte = pio.port_byte_size;
                    r_next.wr_data = pio.port_byte_size ? {24'h000000, y[7:0]} : y;
                end
                dcp_pkg::UC_RD_DATA: begin
                    r_next.ret = pio.port_byte_size
                        ? {24'h000000, rd_data[7:0]} : rd_data;
                end
                default: begin
                end
            endcase
        end

        if (pio.port_clock_pulse) begin
            r_next.chg_p = drive_change;
            if (r_reg.chg_p && r_reg.ie) begin
                r_next.slow_irq = 1'b1;
            end
            case (r_reg.st)
                DV_BUSY: begin
                    if (r_reg.err_p) begin
                        r_next.err = 1'b1;
                        r_next.err_p = func_error;
                        r_next.done_p = func_done;
                        r_next.slow_irq = r_next.slow_irq | r_reg.ie;
                        r_next.st = DV_IDLE;
                    end else if (r_reg.done_p) begin
                        r_next.done_p = func_done;
                        if (xfer_func) begin
                            r_next.xfer_req = 1'b1;
                            r_next.st = DV_XFER;
                        end else begin
                            r_next.slow_irq = r_next.slow_irq | r_reg.ie;
                            r_next.st = DV_IDLE;
                        end
                    end
                end
                DV_XFER: begin
                    if (pio.transfer_grant_ack) begin
                        r_next.xfer_req = 1'b0;
                        r_next.slow_irq = r_next.slow_irq | r_reg.ie;
                        r_next.st = DV_IDLE;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign pio.port_return_bus = r_reg.ret;
    assign pio.fast_transfer_request = r_reg.xfer_req;
    assign pio.slow_bus_interrupt_request = r_reg.slow_irq;
    assign func_start = r_reg.start;
    assign func_code = r_reg.func;
    assign drive_sel = r_reg.drive;
    assign skip_sector_en = r_reg.skip_en;
    assign maint_mode = r_reg.mtn;
    assign format_mode = r_reg.fmt;
    assign write_inhibit = r_reg.winh;
    assign busy = (r_reg.st != DV_IDLE);
    assign dcmd_valid = r_reg.dcmd_v;
    assign dcmd_kind = r_reg.dcmd_kind;
    assign dcmd_word = r_reg.dcmd_word;
    assign wr_valid = r_reg.wr_v;
    assign wr_data = r_reg.wr_data;
    assign wr_byte = r_reg.wr_byte;
endmodule
`default_nettype wire

// [hdl/dcp_pkg.sv]
/*
 Shared constants of the disk controller port.
 Assumes one 10 MHz clock on both ends.
*/
`default_nettype none
package dcp_pkg;
    localparam int unsigned DATA_W = 32;
    localparam logic [4:0] UC_CTRL_WORD = 5'h01;
    localparam logic [4:0] UC_DRV_CMD   = 5'h02;
    localparam logic [4:0] UC_RD_STATUS = 5'h03;
    localparam logic [4:0] UC_WR_DATA   = 5'h04;
    localparam logic [4:0] UC_RD_DATA   = 5'h05;
    localparam int unsigned CW_FN_LSB = 0;
    localparam int unsigned CW_IE     = 6;
    localparam int unsigned CW_CONTROLLER_READY_FLAG   = 7;
    localparam int unsigned CW_DS_LSB = 8;
    localparam int unsigned CW_MTN    = 25;
    localparam int unsigned CW_ASSI   = 27;
    localparam int unsigned CW_WINH   = 28;
    localparam int unsigned CW_FMT    = 29;
    localparam logic [2:0] FN_WR_CHECK = 3'h1;
    localparam logic [2:0] FN_WR_DATA  = 3'h5;
    localparam logic [2:0] FN_RD_DATA  = 3'h6;
    localparam logic [2:0] FN_RD_NOHDR = 3'h7;
    // Kind sits in the low three bits of a drive command
    localparam logic [2:0] DK_GET_STATUS = 3'h1;
    localparam logic [2:0] DK_SEEK_A     = 3'h2;
    localparam logic [2:0] DK_SEEK_B     = 3'h3;
    localparam logic [2:0] DK_HEAD_SEL   = 3'h4;
    localparam logic [2:0] DK_RECAL      = 3'h5;
    localparam int unsigned SW_READY  = 0;
    localparam int unsigned SW_XFER   = 1;
    localparam int unsigned SW_SLOW   = 2;
    localparam int unsigned SW_ERR    = 3;
    localparam int unsigned SW_DS_LSB = 4;
    localparam int unsigned CLK_HZ   = 10_000_000;
    localparam int unsigned PORT_HZ  = 5_000_000;
    localparam int unsigned PHASE_HZ = 2_500_000;
    localparam int unsigned PORT_DIV  = CLK_HZ / PORT_HZ;
    localparam int unsigned PHASE_DIV = CLK_HZ / PHASE_HZ;
    localparam logic [7:0] A_CTRL  = 8'h00;
    localparam logic [7:0] A_DRV   = 8'h04;
    localparam logic [7:0] A_DATA  = 8'h08;
    localparam logic [7:0] A_SIZE  = 8'h0c;
    localparam logic [7:0] A_STAT  = 8'h10;
    localparam logic [7:0] A_MASK  = 8'h14;
    localparam logic [7:0] A_LIVE  = 8'h18;
    localparam logic [7:0] A_DSTAT = 8'h1c;
    localparam int unsigned IRQ_W    = 3;
    localparam int unsigned IRQ_XFER = 0;
    localparam int unsigned IRQ_SLOW = 1;
    localparam int unsigned IRQ_DONE = 2;
endpackage
`default_nettype wire

// [hdl/dcp_port_if.sv]
/*
 Port bus between the processor end and the disk controller end.
 Assumes both ends share one clock; the bench joins the two modports.
*/
`default_nettype none
interface dcp_port_if;
    logic        processor_phase_pulse;
    logic        port_clock_pulse;
    logic [31:0] port_data_bus;
    logic [31:0] port_return_bus;
    logic        port_byte_size;
    logic        microinstruction_select_line;
    logic [4:0]  microinstruction_code_field;
    logic        port_instruction_strobe;
    logic        fast_transfer_request;
    logic        transfer_grant_ack;
    logic        slow_bus_interrupt_request;
    modport dev (
        input  processor_phase_pulse, port_clock_pulse, port_data_bus, port_byte_size,
        input  microinstruction_select_line, microinstruction_code_field,
        input  port_instruction_strobe, transfer_grant_ack,
        output port_return_bus, fast_transfer_request, slow_bus_interrupt_request
    );
    modport host (
        output processor_phase_pulse, port_clock_pulse, port_data_bus, port_byte_size,
        output microinstruction_select_line, microinstruction_code_field,
        output port_instruction_strobe, transfer_grant_ack,
        input  port_return_bus, fast_transfer_request, slow_bus_interrupt_request
    );
endinterface
`default_nettype wire

// [hdl/dcp_pulse_div.sv]
/*
 Divider giving a one-cycle enable pulse every DIV clocks.
 Assumes DIV is between 1 and 256.
*/
`default_nettype none
module dcp_pulse_div #(
    parameter int unsigned DIV = 2
) (
    input  wire logic hclk,
    input  wire logic hresetn,
    output logic      pulse
);
    typedef struct packed {
        logic [7:0] cnt;
        logic       pulse;
    } dcp_div_t;
    dcp_div_t r_reg;
    dcp_div_t r_next;

    always_comb begin
        r_next = r_reg;
        r_next.pulse = (r_reg.cnt == 8'(DIV - 1));
        r_next.cnt = r_next.pulse ? 8'h00 : r_reg.cnt + 8'h01;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign pulse = r_reg.pulse;
endmodule
`default_nettype wire

// [hdl/dcp_host.sv]
/*
 Processor end: AHB-Lite slave turning register accesses into port
 microinstructions; makes timing pulses and grants fast requests.
 Assumes one master and this one slave on the bus.
*/
`default_nettype none
module dcp_host (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    output logic             irq,
    dcp_port_if.host         pio
);
    typedef enum logic [1:0] {
        HS_IDLE,
        HS_ISSUE,
        HS_CAPT
    } dcp_host_state_t;

    typedef struct packed {
        dcp_host_state_t st;
        logic            ph_v;
        logic            ph_wr;
        logic [7:0]      ph_addr;
        logic            rdy;
        logic [31:0]     rdata;
        logic            strobe;
        logic [4:0]      code;
        logic [31:0]     y;
        logic            byte_sz;
        logic            grant;
        logic            req_q;
        logic            slow_q;
        logic [2:0]      stat;
        logic [2:0]      mask;
        logic            irq;
    } dcp_host_s_t;

    dcp_host_s_t r_reg;
    dcp_host_s_t r_next;
    logic        phase;
    logic        port_pulse;
    logic [7:0]  a;
    logic        port_op;

    dcp_pulse_div #(.DIV(dcp_pkg::PHASE_DIV)) u_phase (
        .hclk    (hclk),
        .hresetn (hresetn),
        .pulse   (phase)
    );
    dcp_pulse_div #(.DIV(dcp_pkg::PORT_DIV)) u_port (
        .hclk    (hclk),
        .hresetn (hresetn),
        .pulse   (port_pulse)
    );

    always_comb begin
        r_next = r_reg;
        a = haddr[7:0];
        port_op = hwrite ? (a == dcp_pkg::A_CTRL || a == dcp_pkg::A_DRV || a == dcp_pkg::A_DATA)
                         : (a == dcp_pkg::A_DATA || a == dcp_pkg::A_DSTAT);
        r_next.ph_v = 1'b0;
        // Address phase; hsize is ignored since only whole words are used
        if (hsel && htrans[1] && hready) begin
            r_next.ph_v = 1'b1;
            r_next.ph_wr = hwrite;
            r_next.ph_addr = a;
            r_next.rdy = !port_op;
            case (a)
                dcp_pkg::A_SIZE: r_next.rdata = {31'h00000000, r_reg.byte_sz};
                dcp_pkg::A_STAT: r_next.rdata = {29'h00000000, r_reg.stat};
                dcp_pkg::A_MASK: r_next.rdata = {29'h00000000, r_reg.mask};
                dcp_pkg::A_LIVE: r_next.rdata = {29'h00000000, r_reg.slow_q,
                    r_reg.req_q, r_reg.st != HS_IDLE};
                default: r_next.rdata = 32'h00000000;
            endcase
            if (!hwrite && a == dcp_pkg::A_STAT) begin
                r_next.stat = '0;
            end
        end
        // Data phase: a port access launches one microinstruction
        if (r_reg.ph_v) begin
            r_next.code = 5'h00;
            if (r_reg.ph_wr) begin
                case (r_reg.ph_addr)
                    dcp_pkg::A_CTRL: r_next.code = dcp_pkg::UC_CTRL_WORD;
                    dcp_pkg::A_DRV: r_next.code = dcp_pkg::UC_DRV_CMD;
                    dcp_pkg::A_DATA: r_next.code = dcp_pkg::UC_WR_DATA;
                    dcp_pkg::A_SIZE: r_next.byte_sz = hwdata[0];
                    dcp_pkg::A_MASK: r_next.mask = hwdata[dcp_pkg::IRQ_W-1:0];
                    default: begin
                    end
                endcase
            end else if (r_reg.ph_addr == dcp_pkg::A_DATA) begin
                r_next.code = dcp_pkg::UC_RD_DATA;
            end else if (r_reg.ph_addr == dcp_pkg::A_DSTAT) begin
                r_next.code = dcp_pkg::UC_RD_STATUS;
            end
            if (r_next.code != 5'h00) begin
                r_next.y = r_reg.byte_sz ? {24'h000000, hwdata[7:0]} : hwdata;
                r_next.strobe = 1'b1;
                r_next.st = HS_ISSUE;
            end
        end
        case (r_reg.st)
            HS_ISSUE: begin
                // Held until a phase pulse so the device takes it in step
                if (phase) begin
                    r_next.strobe = 1'b0;
                    if (r_reg.code == dcp_pkg::UC_RD_DATA || r_reg.code == dcp_pkg::UC_RD_STATUS) begin
                        r_next.st = HS_CAPT;
                    end else begin
                        r_next.st = HS_IDLE;
                        r_next.rdy = 1'b1;
                        r_next.stat[dcp_pkg::IRQ_DONE] = 1'b1;
                    end
                end
            end
            HS_CAPT: begin
                r_next.rdata = pio.port_return_bus;
                r_next.rdy = 1'b1;
                r_next.stat[dcp_pkg::IRQ_DONE] = 1'b1;
                r_next.st = HS_IDLE;
            end
            default: begin
            end
        endcase
        if (port_pulse) begin
            r_next.grant = pio.fast_transfer_request && !r_reg.grant;
        end
        r_next.req_q = pio.fast_transfer_request;
        r_next.slow_q = pio.slow_bus_interrupt_request;
        if (pio.fast_transfer_request && !r_reg.req_q) begin
            r_next.stat[dcp_pkg::IRQ_XFER] = 1'b1;
        end
        if (pio.slow_bus_interrupt_request && !r_reg.slow_q) begin
            r_next.stat[dcp_pkg::IRQ_SLOW] = 1'b1;
        end
        r_next.irq = |(r_reg.stat & r_reg.mask);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            r_reg <= '0;
            r_reg.rdy <= 1'b1;
        end else begin
            r_reg <= r_next;
        end
    end

    assign hreadyout = r_reg.rdy;
    assign hresp = 1'b0;
    assign hrdata = r_reg.rdata;
    assign irq = r_reg.irq;
    assign pio.processor_phase_pulse = phase;
    assign pio.port_clock_pulse = port_pulse;
    assign pio.port_data_bus = r_reg.y;
    assign pio.port_byte_size = r_reg.byte_sz;
    assign pio.microinstruction_select_line = r_reg.strobe;
    assign pio.microinstruction_code_field = r_reg.code;
    assign pio.port_instruction_strobe = r_reg.strobe;
    assign pio.transfer_grant_ack = r_reg.grant;
endmodule
`default_nettype wire

// [dv/dcp_port_monitor.sv]
/*
 Assertions on the port bus between the two ends.
 Assumes one clock; signals wired in by name.
*/
`default_nettype none
module dcp_port_monitor (
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        processor_phase_pulse,
    input wire logic        port_clock_pulse,
    input wire logic [31:0] port_data_bus,
    input wire logic        port_byte_size,
    input wire logic        microinstruction_select_line,
    input wire logic [4:0]  microinstruction_code_field,
    input wire logic        port_instruction_strobe,
    input wire logic        fast_transfer_request,
    input wire logic        transfer_grant_ack,
    input wire logic        slow_bus_interrupt_request
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    a_phase_pulse_period:
        assert property (processor_phase_pulse |=> !processor_phase_pulse [*3] ##1
            processor_phase_pulse) else $error("phase spacing");
    a_port_pulse_period:
        assert property (port_clock_pulse |=> !port_clock_pulse ##1 port_clock_pulse)
        else $error("port spacing");
    a_strobe_held_steady:
        assert property (port_instruction_strobe && !processor_phase_pulse |=>
            port_instruction_strobe && $stable(microinstruction_code_field)
            && $stable(port_data_bus)) else $error("strobe unsteady");
    a_select_with_strobe:
        assert property (port_instruction_strobe |-> microinstruction_select_line)
        else $error("no select");
    a_byte_upper_zero:
        assert property (port_instruction_strobe && port_byte_size |->
            port_data_bus[31:8] == 24'h0) else $error("byte upper bits");
    a_grant_on_request:
        assert property ($rose(transfer_grant_ack) |-> fast_transfer_request)
        else $error("stray grant");
    // Grant lasts two clocks, so the request may only fall near a grant
    a_fast_req_held:
        assert property (fast_transfer_request && !transfer_grant_ack
            && !$past(transfer_grant_ack) && !$past(transfer_grant_ack, 2)
            |=> fast_transfer_request) else $error("request dropped early");
    a_fast_req_drops:
        assert property ($rose(transfer_grant_ack) |-> ##[1:4] !fast_transfer_request)
        else $error("request held");
    a_ctrl_clears_slow:
        assert property (port_instruction_strobe && microinstruction_select_line
            && processor_phase_pulse && microinstruction_code_field == dcp_pkg::UC_CTRL_WORD
            |-> ##[1:2] !slow_bus_interrupt_request) else $error("slow not cleared");
endmodule
`default_nettype wire

// [dv/disk_controller_cpu_port_tb.sv]
/*
 Self-checking bench for both port ends over AHB-Lite.
 Assumes the package's register map.
*/
`default_nettype none
module disk_controller_cpu_port_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hreadyout, irq, busy;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, rd_data = 0, q, wr_data, last_wr;
    logic [1:0]  htrans = 0, drive_sel;
    logic [2:0]  hsize = 0, func_code, dcmd_kind, last_kind;
    logic        func_start, skip_sector_en, dcmd_valid, wr_valid, wr_byte, last_byte;
    logic        func_done = 0, func_error = 0, drive_change = 0;
    int          failures = 0, check_count = 0, cyc = 0, n_start = 0, n_dcmd = 0, s;
    always #50 hclk = ~hclk;
    dcp_port_if pif ();
    dcp_host dcp_host_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hreadyout, .hresp(), .hrdata, .irq, .pio(pif.host));
    dcp_device dcp_device_i (.hclk, .hresetn, .pio(pif.dev), .func_done, .func_error,
        .drive_change, .rd_data, .func_start, .func_code, .drive_sel, .skip_sector_en,
        .maint_mode(), .format_mode(), .write_inhibit(), .busy, .dcmd_valid, .dcmd_kind,
        .dcmd_word(), .wr_valid, .wr_data, .wr_byte);
    dcp_port_monitor dcp_port_monitor_i (.hclk, .hresetn,
        .processor_phase_pulse(pif.processor_phase_pulse),
        .port_clock_pulse(pif.port_clock_pulse), .port_data_bus(pif.port_data_bus),
        .port_byte_size(pif.port_byte_size),
        .microinstruction_select_line(pif.microinstruction_select_line),
        .microinstruction_code_field(pif.microinstruction_code_field),
        .port_instruction_strobe(pif.port_instruction_strobe),
        .fast_transfer_request(pif.fast_transfer_request),
        .transfer_grant_ack(pif.transfer_grant_ack),
        .slow_bus_interrupt_request(pif.slow_bus_interrupt_request));
    // Pulses are caught mid-cycle, away from the edge that launches them
    always @(negedge hclk) begin
        if (func_start === 1'b1)
            n_start++;
        if (dcmd_valid === 1'b1) begin
            n_dcmd++;
            last_kind = dcmd_kind;
        end
        if (wr_valid === 1'b1) begin
            last_wr = wr_data;
            last_byte = wr_byte;
        end
    end
    always @(posedge hclk) begin
        cyc++;
        if (cyc == 20000) begin
            failures++;
            complete_run();
        end
    end
    task automatic complete_run;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t ns: saw %h, wanted %h", $time, seen, exp);
        end
    endtask
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'b10;
        hwrite <= wr;
        hsize <= 3'b010;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        q = hrdata;
    endtask
    task automatic pulse(input logic [2:0] sel);
        @(posedge hclk);
        {func_done, func_error, drive_change} <= sel;
        @(posedge hclk);
        {func_done, func_error, drive_change} <= 3'b000;
    endtask
    task automatic wait_idle;
        int i;
        i = 0;
        while ((busy !== 1'b0 || pif.fast_transfer_request !== 1'b0) && i < 200) begin
            @(posedge hclk);
            i++;
        end
        chk(32'(i < 200), 32'h1);
        repeat (3) @(posedge hclk);
    endtask
    task automatic t_regs;
        ahb(1'b0, 8'h40, 32'h0);
        chk(q, 32'h0);
        ahb(1'b0, dcp_pkg::A_STAT, 32'h0);
        chk(q, 32'h0);
        ahb(1'b1, dcp_pkg::A_SIZE, 32'h1);
        ahb(1'b0, dcp_pkg::A_SIZE, 32'h0);
        chk(q, 32'h1);
        ahb(1'b1, dcp_pkg::A_MASK, 32'h7);
        $display("test regs done");
    endtask
    task automatic t_data;
        ahb(1'b1, dcp_pkg::A_DATA, 32'ha5c3_1e78);
        repeat (2) @(posedge hclk);
        chk({last_wr[30:0], last_byte}, {31'h78, 1'b1});
        ahb(1'b1, dcp_pkg::A_SIZE, 32'h0);
        ahb(1'b1, dcp_pkg::A_DATA, 32'ha5c3_1e78);
        repeat (2) @(posedge hclk);
        chk(last_wr, 32'ha5c3_1e78);
        chk(32'(last_byte), 32'h0);
        rd_data <= 32'h1357_9bdf;
        ahb(1'b0, dcp_pkg::A_DATA, 32'h0);
        chk(q, 32'h1357_9bdf);
        $display("test data done");
    endtask
    task automatic t_drive_cmds;
        for (int k = 0; k < 6; k++) begin
            s = n_dcmd;
            ahb(1'b1, dcp_pkg::A_DRV, 32'h00ab_cd00 | k);
            repeat (2) @(posedge hclk);
            chk(32'(n_dcmd - s), 32'(k > 0));
            if (k > 0)
                chk(32'(last_kind), 32'(k));
        end
        $display("test drive done");
    endtask
    task automatic t_transfer;
        logic [31:0] w [4] = '{32'h0000_0346, 32'h0800_0105, 32'h0000_0241, 32'h0000_0307};
        foreach (w[k]) begin
            s = n_start;
            ahb(1'b1, dcp_pkg::A_CTRL, w[k]);
            ahb(1'b0, dcp_pkg::A_STAT, 32'h0);
            chk(32'(n_start - s), 32'h1);
            chk(32'({func_code, drive_sel, skip_sector_en}),
                32'({w[k][2:0], w[k][9:8], !w[k][27]}));
            pulse(3'b100);
            wait_idle();
            chk(32'(irq), 32'h1);
            ahb(1'b0, dcp_pkg::A_STAT, 32'h0);
            chk(q, {30'h0, w[k][6], 1'b1});
        end
        $display("test transfers done");
    endtask
    task automatic t_error;
        ahb(1'b1, dcp_pkg::A_CTRL, 32'h0000_0042);
        ahb(1'b0, dcp_pkg::A_STAT, 32'h0);
        pulse(3'b010);
        wait_idle();
        ahb(1'b0, dcp_pkg::A_STAT, 32'h0);
        chk(q, 32'h2);
        $display("test error halt done");
    endtask
    task automatic t_not_ready;
        s = n_start;
        ahb(1'b1, dcp_pkg::A_MASK, 32'h0);
        ahb(1'b1, dcp_pkg::A_CTRL, 32'h0000_00c6);
        repeat (2) @(posedge hclk);
        chk(32'(n_start - s), 32'h0);
        pulse(3'b001);
        repeat (4) @(posedge hclk);
        chk(32'(irq), 32'h0);
        ahb(1'b1, dcp_pkg::A_MASK, 32'h7);
        repeat (2) @(posedge hclk);
        chk(32'(irq), 32'h1);
        ahb(1'b0, dcp_pkg::A_STAT, 32'h0);
        chk(q, 32'h6);
        ahb(1'b1, dcp_pkg::A_CTRL, 32'h0000_0080);
        ahb(1'b0, dcp_pkg::A_STAT, 32'h0);
        pulse(3'b001);
        repeat (4) @(posedge hclk);
        ahb(1'b0, dcp_pkg::A_STAT, 32'h0);
        chk(q, 32'h0);
        $display("test ready done");
    endtask
    initial begin
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        t_regs();
        t_data();
        t_drive_cmds();
        t_transfer();
        t_error();
        t_not_ready();
        complete_run();
    end
endmodule
`default_nettype wire
